/* logic/i2c_secondary_pkg.sv */
package i2c_secondary_pkg;
  // 7-bit bus address is this base with the select pin as bit 0
  localparam logic [6:0] ADDR_BASE       = 7'h0c;
  localparam logic [6:0] ADDR_SEL_LOW    = 7'h18;
  localparam logic [6:0] ADDR_SEL_HIGH   = 7'h19;
  localparam int         CLK_PERIOD_NS   = 10;
  localparam int         GLITCH_NS       = 50;
  // a spike up to the glitch width is rejected: need one cycle more than it spans
  localparam int         GLITCH_CYCLES   = GLITCH_NS / CLK_PERIOD_NS + 1;
  localparam int         STRETCH_MAX_NS  = 1000;
  // longest time rounds down
  localparam int         STRETCH_CYCLES  = STRETCH_MAX_NS / CLK_PERIOD_NS;
  // stretch actually used: short, well below the ceiling
  localparam int         STRETCH_USE     = 8;
  localparam logic [7:0] PTR_RESET       = 8'h00;
  localparam logic [7:0] DATA_RESET      = 8'h00;
endpackage

/* logic/line_filter.sv */
`timescale 1ns/1ns
`default_nettype none
// two-flop synchroniser followed by a stability filter
module line_filter #(
  parameter int CYCLES = 6
) (
  input  wire logic core_clk_in,
  input  wire logic rst_b_in,
  input  wire logic line_in,
  output var  logic line_out
);
  logic       meta_q;
  logic       sync_q;
  logic [3:0] cnt_q;

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= line_in;
      sync_q <= meta_q;
    end
  end

  // output follows only after the new level held CYCLES clocks
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q    <= 4'h0;
      line_out <= 1'b1;
    end else if (sync_q == line_out) begin
      cnt_q <= 4'h0;
    end else if (cnt_q == 4'(CYCLES - 1)) begin
      cnt_q    <= 4'h0;
      line_out <= sync_q;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule
`default_nettype wire

/* logic/i2c_secondary_port.sv */
//
// Overview of operation
// - address 18h, or 19h with select high
// - address byte is seven bits plus direction
// - SDA fall with SCL high is start
// - SDA rise with SCL high is stop
// - selected only on exact address match
// - ninth clock of every byte is acknowledge
// - transmitter releases SDA during acknowledge
// - receiver holds SDA low through ack high
// - no limit on bytes per transfer
// - read stretch after primary ack, under 1us
// - primary nak ends read data driving
// - repeated start handled as a start
// - both lines released while idle
// - spikes up to 50 ns filtered out
// - first write byte is register pointer
// - pointer advances after each read byte
// - pointer advances after each written byte
`timescale 1ns/1ns
`default_nettype none
module i2c_secondary_port #(
  parameter int STRETCH = i2c_secondary_pkg::STRETCH_USE
) (
  input  wire logic       core_clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       address_select_pin_in,
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe_out,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  output logic [7:0]      reg_addr_out,
  output logic [7:0]      wr_data_out,
  output logic            wr_strobe_out,
  output logic            rd_strobe_out,
  input  wire logic [7:0] rd_data_in,
  output logic            busy_out
);
  typedef enum {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK, ST_IGNORE
  } state_e;

  //////////////////////////////////////////////////////////////////////////////
  // filtered line samples
  logic scl_f;
  logic sda_f;
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  line_filter #(.CYCLES(i2c_secondary_pkg::GLITCH_CYCLES)) scl_filt (
    .core_clk_in (core_clk_in),
    .rst_b_in    (rst_b_in),
    .line_in     (scl_in),
    .line_out    (scl_f)
  );
  line_filter #(.CYCLES(i2c_secondary_pkg::GLITCH_CYCLES)) sda_filt (
    .core_clk_in (core_clk_in),
    .rst_b_in    (rst_b_in),
    .line_in     (sda_in),
    .line_out    (sda_f)
  );

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_f;
      sda_prev_q <= sda_f;
    end
  end

  assign scl_rise  = scl_f & ~scl_prev_q;
  assign scl_fall  = ~scl_f & scl_prev_q;
  assign start_det = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
  assign stop_det  = scl_f & scl_prev_q & ~sda_prev_q & sda_f;

  //////////////////////////////////////////////////////////////////////////////
  // byte shifter and protocol state
  state_e      state_q;
  logic [3:0]  bit_cnt_q;
  logic [7:0]  shift_q;
  logic [7:0]  ptr_q;
  logic [7:0]  tx_q;
  logic        nak_q;
  logic [6:0]  own_addr;
  logic        stretch_req_q;
  logic [7:0]  byte_in;

  // the select pin is a board strap, but it still comes from outside the clock domain
  logic sel_meta_q;
  logic sel_sync_q;

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sel_meta_q <= 1'b0;
      sel_sync_q <= 1'b0;
    end else begin
      sel_meta_q <= address_select_pin_in;
      sel_sync_q <= sel_meta_q;
    end
  end

  assign own_addr = sel_sync_q ? i2c_secondary_pkg::ADDR_SEL_HIGH
                               : i2c_secondary_pkg::ADDR_SEL_LOW;
  assign byte_in  = {shift_q[6:0], sda_f};

  function automatic logic is_rx(input state_e s);
    is_rx = (s == ST_ADDR) || (s == ST_PTR) || (s == ST_WDATA);
  endfunction

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q   <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= i2c_secondary_pkg::DATA_RESET;
      nak_q     <= 1'b0;
    end else if (start_det) begin
      state_q   <= ST_ADDR;
      bit_cnt_q <= 4'h0;
    end else if (stop_det) begin
      state_q   <= ST_IDLE;
    end else if (scl_rise) begin
      if (is_rx(state_q)) begin
        shift_q   <= byte_in;
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
      case (state_q)
        ST_RDATA: begin
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
        ST_RDATA_ACK: begin
          nak_q <= sda_f;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (state_q)
        ST_ADDR: begin
          if (bit_cnt_q == 4'h8) begin
            bit_cnt_q <= 4'h0;
            state_q   <= (shift_q[7:1] == own_addr) ? ST_ADDR_ACK : ST_IGNORE;
          end
        end
        ST_PTR, ST_WDATA: begin
          if (bit_cnt_q == 4'h8) begin
            bit_cnt_q <= 4'h0;
            state_q   <= (state_q == ST_PTR) ? ST_PTR_ACK : ST_WDATA_ACK;
          end
        end
        ST_ADDR_ACK: begin
          state_q <= shift_q[0] ? ST_RDATA : ST_PTR;
        end
        ST_PTR_ACK, ST_WDATA_ACK: begin
          state_q <= ST_WDATA;
        end
        ST_RDATA: begin
          if (bit_cnt_q == 4'h8) begin
            bit_cnt_q <= 4'h0;
            state_q   <= ST_RDATA_ACK;
          end
        end
        ST_RDATA_ACK: begin
          state_q <= nak_q ? ST_IGNORE : ST_RDATA;
        end
        default: begin
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register pointer and data exchange with the register file
  logic link_fall;
  logic load_tx;

  // a fall that coincides with a start or stop belongs to that condition
  assign link_fall = !start_det && !stop_det && scl_fall;
  assign load_tx   = (state_q == ST_ADDR_ACK && shift_q[0]) ||
                     (state_q == ST_RDATA_ACK && !nak_q);

  function automatic logic byte_done(input logic [3:0] cnt);
    byte_done = (cnt == 4'h8);
  endfunction

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ptr_q <= i2c_secondary_pkg::PTR_RESET;
    end else if (link_fall) begin
      if (state_q == ST_PTR && byte_done(bit_cnt_q)) begin
        ptr_q <= shift_q;
      end else if (state_q == ST_WDATA_ACK) begin
        ptr_q <= ptr_q + 8'h01;
      end else if (load_tx) begin
        ptr_q <= ptr_q + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_data_out   <= i2c_secondary_pkg::DATA_RESET;
      wr_strobe_out <= 1'b0;
    end else begin
      wr_strobe_out <= 1'b0;
      if (link_fall && state_q == ST_WDATA && byte_done(bit_cnt_q)) begin
        wr_data_out   <= shift_q;
        wr_strobe_out <= 1'b1;
      end
    end
  end

  // the byte to send is taken at the fall that opens its first bit
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_q          <= i2c_secondary_pkg::DATA_RESET;
      rd_strobe_out <= 1'b0;
    end else begin
      rd_strobe_out <= 1'b0;
      if (link_fall && load_tx) begin
        tx_q          <= rd_data_in;
        rd_strobe_out <= 1'b1;
      end else if (link_fall && state_q == ST_RDATA) begin
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_addr_out <= i2c_secondary_pkg::PTR_RESET;
    end else begin
      reg_addr_out <= ptr_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin drivers: open drain, only ever pull low
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sda_oe_out <= 1'b0;
      sda_out    <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      case (state_q)
        ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK: sda_oe_out <= 1'b1;
        // only a zero bit pulls the line; released in the ack slot
        ST_RDATA: sda_oe_out <= (bit_cnt_q != 4'h8 || scl_f) ? ~tx_q[7] : 1'b0;
        default: sda_oe_out <= 1'b0;
      endcase
      if (start_det || stop_det) begin
        sda_oe_out <= 1'b0;
      end
    end
  end

  // short stretch after the primary ack starts at the same fall that takes the byte from the register file;
  // the cap keeps it inside the documented limit regardless of STRETCH
  logic [7:0] stretch_cnt_q;
  localparam int STRETCH_EFF = (STRETCH < i2c_secondary_pkg::STRETCH_CYCLES) ?
                               STRETCH : i2c_secondary_pkg::STRETCH_CYCLES;

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      stretch_req_q <= 1'b0;
      stretch_cnt_q <= 8'h00;
    end else if (start_det || stop_det) begin
      stretch_req_q <= 1'b0;
    end else if (scl_fall && state_q == ST_RDATA_ACK && !nak_q) begin
      stretch_req_q <= 1'b1;
      stretch_cnt_q <= 8'(STRETCH_EFF);
    end else if (stretch_req_q) begin
      if (stretch_cnt_q <= 8'h01) begin
        stretch_req_q <= 1'b0;
      end
      stretch_cnt_q <= stretch_cnt_q - 8'h01;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scl_oe_out <= 1'b0;
      scl_out    <= 1'b0;
      busy_out   <= 1'b0;
    end else begin
      scl_out    <= 1'b0;
      scl_oe_out <= stretch_req_q && !(stretch_cnt_q <= 8'h01);
      busy_out   <= (state_q != ST_IDLE) && !stop_det;
    end
  end
endmodule
`default_nettype wire

/* test/i2c_secondary_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module i2c_secondary_properties (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic scl_out,
  input wire logic scl_oe_out,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic wr_strobe_out,
  input wire logic rd_strobe_out,
  input wire logic busy_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  AST_IDLE_RELEASED:
    assert property (!busy_out |-> !sda_oe_out && !scl_oe_out) else $error("idle line driven");
  AST_OPEN_DRAIN:
    assert property (!scl_out && !sda_out) else $error("line driven high");
  AST_STRETCH_MAX:
    assert property ($rose(scl_oe_out) |-> ##[1:100] !scl_oe_out) else $error("stretch too long");
  AST_SDA_STEADY_HIGH:
    assert property (scl_in [*8] ##1 scl_in |-> $stable(sda_oe_out)) else $error("sda moved");
  // a start or stop only counts once it outlasts the spike filter
  AST_START_BUSY:
    assert property ($fell(sda_in) && scl_in ##1 (!sda_in && scl_in) [*8] |-> ##[1:12] busy_out)
    else $error("start missed");
  AST_STOP_IDLE:
    assert property ($rose(sda_in) && scl_in ##1 (sda_in && scl_in) [*8] |-> ##[1:12] !busy_out)
    else $error("stop missed");
  AST_WR_PULSE:
    assert property (wr_strobe_out |-> busy_out ##1 !wr_strobe_out) else $error("bad write pulse");
  AST_RD_PULSE:
    assert property (rd_strobe_out |-> busy_out ##1 !rd_strobe_out) else $error("bad read pulse");
endmodule
////////////////////////////////////////////////////////////////
bind i2c_secondary_port i2c_secondary_properties u_i2c_secondary_properties (.*);
`default_nettype wire

/* test/i2c_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module i2c_host_model (
  input  wire logic core_clk_in,
  input  wire logic scl_val_in,
  input  wire logic scl_oe_in,
  input  wire logic sda_val_in,
  input  wire logic sda_oe_in,
  output var  logic scl_wire_out,
  output var  logic sda_wire_out
);
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  // pull-ups: a released line rests high
  assign scl_wire_out = scl_q & (scl_oe_in ? scl_val_in : 1'b1);
  assign sda_wire_out = sda_q & (sda_oe_in ? sda_val_in : 1'b1);
  ////////////////////////////////////////////////////////////////
  // quarter bit of 500 ns leaves room for the secondary's input latency
  task automatic lv(input logic c, input logic d);
    scl_q <= c;
    sda_q <= d;
    repeat (50) @(posedge core_clk_in);
  endtask
  task automatic bit_x(input logic b, output logic r);
    int k;
    k = 0;
    lv(1'b0, b);
    scl_q <= 1'b1;
    @(posedge core_clk_in);
    while (scl_wire_out !== 1'b1 && k < 200) begin
      @(posedge core_clk_in);
      k++;
    end
    if (k == 200) begin
      tb.n_errors++;
      $display("unexpected scl level expected 1 seen 0");
      tb.end_of_test();
    end
    repeat (50) @(posedge core_clk_in);
    r = sda_wire_out;
    lv(1'b1, b);
    lv(1'b0, b);
  endtask
  task automatic start;
    lv(1'b0, 1'b1);
    lv(1'b1, 1'b1);
    lv(1'b1, 1'b0);
    lv(1'b0, 1'b0);
  endtask
  task automatic stop;
    lv(1'b0, 1'b0);
    lv(1'b1, 1'b0);
    lv(1'b1, 1'b1);
  endtask
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, ack);
  endtask
  task automatic get(input logic nak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(nak, r);
  endtask
  // 40 ns dips on each line while idle
  task automatic spike;
    sda_q <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    sda_q <= 1'b1;
    repeat (20) @(posedge core_clk_in);
    scl_q <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    scl_q <= 1'b1;
    repeat (20) @(posedge core_clk_in);
  endtask
endmodule
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic       core_clk_in = 1'b0;
  logic       rst_b_in = 1'b0;
  logic       sel_q = 1'b0;
  logic [7:0] rd_data_q = 8'h00;
  wire logic  scl_w, sda_w, scl_o, scl_oe, sda_o, sda_oe, wr_stb, rd_stb, busy;
  wire logic [7:0] reg_addr, wr_data;
  int         n_errors = 0;
  int         samples_checked = 0;
  int         n_rd = 0;
  int         n_stretch = 0;
  logic [7:0] wr_log[$];
  always #5 core_clk_in = ~core_clk_in;
  // register file stand-in: contents follow the pointer
  always @(posedge core_clk_in) rd_data_q <= reg_addr ^ 8'h3c;
  always @(posedge core_clk_in) if (wr_stb === 1'b1) wr_log.push_back(wr_data);
  always @(posedge core_clk_in) if (rd_stb === 1'b1) n_rd++;
  always @(posedge core_clk_in) if (scl_oe === 1'b1) n_stretch++;
  i2c_secondary_port u_i2c_secondary_port (
    .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .address_select_pin_in(sel_q),
    .scl_in(scl_w), .scl_out(scl_o), .scl_oe_out(scl_oe), .sda_in(sda_w), .sda_out(sda_o),
    .sda_oe_out(sda_oe), .reg_addr_out(reg_addr), .wr_data_out(wr_data),
    .wr_strobe_out(wr_stb), .rd_strobe_out(rd_stb), .rd_data_in(rd_data_q), .busy_out(busy));
  i2c_host_model u_i2c_host_model (
    .core_clk_in(core_clk_in), .scl_val_in(scl_o), .scl_oe_in(scl_oe), .sda_val_in(sda_o),
    .sda_oe_in(sda_oe), .scl_wire_out(scl_w), .sda_wire_out(sda_w));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test;
    if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic t_spike;
    u_i2c_host_model.spike();
    chk("busy", 8'h00, {7'h00, busy});
  endtask
  task automatic t_write;
    logic       a;
    logic [7:0] d [3] = '{8'ha1, 8'h5e, 8'hc3};
    sel_q <= 1'b0;
    u_i2c_host_model.start();
    u_i2c_host_model.put(8'h30, a);
    chk("addr ack", 8'h00, {7'h00, a});
    chk("busy", 8'h01, {7'h00, busy});
    u_i2c_host_model.put(8'h10, a);
    chk("ptr ack", 8'h00, {7'h00, a});
    for (int i = 0; i < 3; i++) u_i2c_host_model.put(d[i], a);
    chk("data ack", 8'h00, {7'h00, a});
    u_i2c_host_model.stop();
    chk("busy", 8'h00, {7'h00, busy});
    chk("writes", 8'h03, 8'(wr_log.size()));
    for (int i = 0; i < 3 && i < wr_log.size(); i++) chk("wdata", d[i], wr_log[i]);
    chk("pointer", 8'h13, reg_addr);
  endtask
  task automatic t_read;
    logic       a;
    logic [7:0] v;
    sel_q <= 1'b1;
    u_i2c_host_model.start();
    u_i2c_host_model.put(8'h32, a);
    chk("addr ack", 8'h00, {7'h00, a});
    u_i2c_host_model.put(8'h20, a);
    u_i2c_host_model.start();
    u_i2c_host_model.put(8'h33, a);
    chk("raddr ack", 8'h00, {7'h00, a});
    for (int i = 0; i < 3; i++) begin
      u_i2c_host_model.get(i == 2, v);
      chk("rdata", (8'h20 + 8'(i)) ^ 8'h3c, v);
    end
    chk("sda after nak", 8'h00, {7'h00, sda_oe});
    chk("read loads", 8'h03, 8'(n_rd));
    chk("pointer", 8'h23, reg_addr);
    chk("stretch seen", 8'h01, {7'h00, n_stretch > 0});
    chk("stretch short", 8'h01, {7'h00, n_stretch <= 200});
    u_i2c_host_model.stop();
  endtask
  task automatic t_mismatch;
    logic a;
    u_i2c_host_model.start();
    u_i2c_host_model.put(8'h30, a);
    chk("foreign ack", 8'h01, {7'h00, a});
    u_i2c_host_model.put(8'h00, a);
    chk("foreign data ack", 8'h01, {7'h00, a});
    u_i2c_host_model.stop();
  endtask
  initial begin
    repeat (6) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    repeat (10) @(posedge core_clk_in);
    t_spike();
    t_write();
    t_read();
    t_mismatch();
    end_of_test();
  end
  initial begin
    repeat (100000) @(posedge core_clk_in);
    n_errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
